// ==== logic/tcl_defines.vh ====
// register offsets, field positions, reset values and timing figures of the trigger/line/cycle bank
`ifndef TCL_DEFINES_VH
`define TCL_DEFINES_VH

// register offsets
`define TCL_ADDR_W              5
`define TCL_OFS_TRIGGER_STROBE  5'h0F
`define TCL_OFS_LINE_CONFIG_A   5'h10
`define TCL_OFS_LINE_CONFIG_B   5'h11
`define TCL_OFS_CYCLE_PERIOD_A  5'h12
`define TCL_OFS_CYCLE_PERIOD_B  5'h13

// trigger register fields
`define TCL_TRIG_CODE_MSB       3
`define TCL_TRIG_CODE_LSB       0
`define TCL_TRIG_GLOBAL_CODE    4'h0
`define TCL_TRIG_RESET          4'h0

// line configuration fields
`define TCL_LC_THRESH_BIT       7
`define TCL_LC_DIR_BIT          6
`define TCL_LC_LEVEL_MSB        5
`define TCL_LC_LEVEL_LSB        4
`define TCL_LC_LOWSIDE_BIT      3
`define TCL_LC_TOTEM_BIT        2
`define TCL_LC_DRV_OFF_BIT      1
`define TCL_LC_FILTER_BIT       0
`define TCL_LC_RESET            8'h02

// current level codes
`define TCL_LEVEL_OFF           2'h0
`define TCL_LEVEL_5MA           2'h1
`define TCL_LEVEL_2MA           2'h2
`define TCL_LEVEL_150UA         2'h3

// cycle period fields
`define TCL_CP_BASE_MSB         7
`define TCL_CP_BASE_LSB         6
`define TCL_CP_MULT_MSB         5
`define TCL_CP_MULT_LSB         0
`define TCL_CP_RESET            8'h00
`define TCL_BASE_FINE           2'h0
`define TCL_BASE_MID            2'h1
`define TCL_BASE_COARSE         2'h2
`define TCL_BASE_INVALID        2'h3

// cycle time in 0.1 ms units: offset and step per base
`define TCL_MID_OFFSET_UNITS    11'h040
`define TCL_MID_STEP_UNITS      11'h004
`define TCL_COARSE_OFFSET_UNITS 11'h140
`define TCL_COARSE_STEP_UNITS   11'h010

// timing
`define TCL_CLK_PERIOD_PS       5000
`define TCL_UNIT_TIME_PS        100000000
`define TCL_UNIT_CYC            (`TCL_UNIT_TIME_PS / `TCL_CLK_PERIOD_PS)
`define TCL_FILTER_TIME_PS      1300000
`define TCL_FILTER_CYC          (`TCL_FILTER_TIME_PS / `TCL_CLK_PERIOD_PS)

`endif

// ==== logic/tcl_channel.v ====
// one channel: line driver steering, receive glitch filter and cycle timer
`timescale 1ns/1ps
`include "tcl_defines.vh"

module tcl_channel #(
    parameter UNIT_CYC = `TCL_UNIT_CYC,
    parameter FILT_CYC = `TCL_FILTER_CYC
) (
    // clock and reset
    input  wire       ref_clk_i,
    input  wire       rst_i,
    // configuration
    input  wire [7:0] line_cfg_i,
    input  wire [7:0] period_cfg_i,
    input  wire       cycle_timer_on_i,
    input  wire       trig_start_i,
    // line
    input  wire       tx_data_i,
    input  wire       line_pin_i,
    output reg        line_pin_o,
    output reg        line_pin_oe_o,
    output reg        rx_data_o,
    // events
    output wire       tx_start_o,
    output wire       timer_running_o
);

    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // cycle length in 0.1 ms units, zero when not usable
    function [10:0] period_units;
        input [7:0] cfg;
        reg   [1:0] base;
        reg   [10:0] mult;
        begin
            base = cfg[`TCL_CP_BASE_MSB:`TCL_CP_BASE_LSB];
            mult = {5'h00, cfg[`TCL_CP_MULT_MSB:`TCL_CP_MULT_LSB]};
            case (base)
                `TCL_BASE_FINE:   period_units = mult;
                `TCL_BASE_MID:    period_units = `TCL_MID_OFFSET_UNITS + mult * `TCL_MID_STEP_UNITS;
                `TCL_BASE_COARSE: period_units = `TCL_COARSE_OFFSET_UNITS + mult * `TCL_COARSE_STEP_UNITS;
                default:          period_units = 11'h000;
            endcase
        end
    endfunction

    wire [10:0] units   = period_units(period_cfg_i);
    wire        usable  = (units != 11'h000);
    reg         state_reg;
    reg         state_next;
    reg  [31:0] pre_reg;
    reg  [10:0] unit_reg;
    wire        pre_wrap = (pre_reg == UNIT_CYC - 1);
    wire        expire   = (state_reg == ST_RUN) && pre_wrap && (unit_reg == 11'h001);

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (trig_start_i && cycle_timer_on_i && usable) state_next = ST_RUN;
            ST_RUN:  if (!cycle_timer_on_i || !usable) state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            pre_reg   <= 32'h0000_0000;
            unit_reg  <= 11'h000;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE || trig_start_i || expire) begin
                pre_reg  <= 32'h0000_0000;
                unit_reg <= units;
            end else if (pre_wrap) begin
                pre_reg  <= 32'h0000_0000;
                unit_reg <= unit_reg - 11'h001;
            end else begin
                pre_reg  <= pre_reg + 32'h0000_0001;
            end
        end
    end

    assign tx_start_o      = trig_start_i | expire;
    assign timer_running_o = (state_reg == ST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // driver steering
    wire drv_off  = line_cfg_i[`TCL_LC_DRV_OFF_BIT];
    wire totem    = line_cfg_i[`TCL_LC_TOTEM_BIT];
    wire low_side = line_cfg_i[`TCL_LC_LOWSIDE_BIT];

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            line_pin_o    <= 1'b0;
            line_pin_oe_o <= 1'b0;
        end else if (drv_off) begin
            line_pin_o    <= 1'b0;
            line_pin_oe_o <= 1'b0;
        end else if (totem) begin
            line_pin_o    <= tx_data_i;
            line_pin_oe_o <= 1'b1;
        end else if (low_side) begin
            line_pin_o    <= 1'b0;
            line_pin_oe_o <= ~tx_data_i;
        end else begin
            line_pin_o    <= 1'b1;
            line_pin_oe_o <= tx_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive glitch filter: level must hold FILT_CYC cycles
    reg [15:0] filt_reg;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            filt_reg  <= 16'h0000;
            rx_data_o <= 1'b0;
        end else if (!line_cfg_i[`TCL_LC_FILTER_BIT] || line_pin_i == rx_data_o) begin
            filt_reg  <= 16'h0000;
            if (!line_cfg_i[`TCL_LC_FILTER_BIT]) rx_data_o <= line_pin_i;
        end else if (filt_reg == FILT_CYC - 1) begin
            filt_reg  <= 16'h0000;
            rx_data_o <= line_pin_i;
        end else begin
            filt_reg  <= filt_reg + 16'h0001;
        end
    end

endmodule // tcl_channel

// ==== logic/tcl_bank.v ====
// trigger, line configuration and cycle timer register bank of a two-channel link master
//
// What this block does
// - the trigger register holds a write-only four-bit code in bits 3:0, upper bits unused, reset to zero.
// - a written code that equals a channel's assigned code starts that channel's cycle timer if on and its send.
// - a trigger write is taken whatever the bus address field says, so all devices on the bus latch it.
// - each channel has a four-bit assigned code and code zero is a global trigger for both channels.
// - trigger start applies to a channel only while its code match enable is set.
// - line config bit 7 picks type 1 thresholds when zero and type 2/3 thresholds when one.
// - line config bit 6 picks current source when one and current sink when zero.
// - line config bits 5:4 set the current: off, 5 mA, 2 mA or 150 uA.
// - line config bit 3 picks low-side when one and high-side when zero, ignored in push-pull mode.
// - line config bit 2 picks push-pull when one and open-drain when zero.
// - line config bit 1 disables the driver when one, leaving the pin undriven, and resets to one.
// - line config bit 0 enables a receive glitch filter of about 1.3 us.
// - the cycle period register holds a time base in bits 7:6 and a multiplier in bits 5:0, reset zero.
// - the cycle timer runs only while its separate enable is set.
// - cycle time is M x 0.1 ms, 6.4 ms + M x 0.4 ms, 32 ms + M x 1.6 ms, base 11 invalid.
// - channel B has its own line config and cycle period registers identical to channel A.
`timescale 1ns/1ps
`include "tcl_defines.vh"

module tcl_bank #(
    parameter UNIT_CYC = `TCL_UNIT_CYC,
    parameter FILT_CYC = `TCL_FILTER_CYC
) (
    // clock and reset
    input  wire                   ref_clk_i,
    input  wire                   rst_i,
    // register port
    input  wire                   reg_wr_i,
    input  wire                   reg_rd_i,
    input  wire                   chip_match_i,
    input  wire [`TCL_ADDR_W-1:0] reg_addr_i,
    input  wire [7:0]             reg_wdata_i,
    output reg  [7:0]             reg_rdata_o,
    output reg                    reg_rvalid_o,
    // trigger assignment and control from neighbouring registers
    input  wire [3:0]             assigned_start_code_a_i,
    input  wire [3:0]             assigned_start_code_b_i,
    input  wire                   code_match_on_a_i,
    input  wire                   code_match_on_b_i,
    input  wire                   cycle_timer_on_a_i,
    input  wire                   cycle_timer_on_b_i,
    // framer side
    input  wire                   tx_data_a_i,
    input  wire                   tx_data_b_i,
    output wire                   tx_start_a_o,
    output wire                   tx_start_b_o,
    output wire                   timer_running_a_o,
    output wire                   timer_running_b_o,
    output wire                   rx_data_a_o,
    output wire                   rx_data_b_o,
    // line pins
    input  wire                   line_pin_a_i,
    output wire                   line_pin_a_o,
    output wire                   line_pin_a_oe_o,
    input  wire                   line_pin_b_i,
    output wire                   line_pin_b_o,
    output wire                   line_pin_b_oe_o,
    // analog front-end controls, channel A
    output wire                   threshold_type_sel_a_o,
    output wire                   current_dir_sel_a_o,
    output wire [1:0]             current_level_sel_a_o,
    output wire                   low_side_polarity_a_o,
    output wire                   totem_pole_mode_a_o,
    output wire                   line_driver_off_a_o,
    output wire                   rx_glitch_filter_on_a_o,
    // analog front-end controls, channel B
    output wire                   threshold_type_sel_b_o,
    output wire                   current_dir_sel_b_o,
    output wire [1:0]             current_level_sel_b_o,
    output wire                   low_side_polarity_b_o,
    output wire                   totem_pole_mode_b_o,
    output wire                   line_driver_off_b_o,
    output wire                   rx_glitch_filter_on_b_o
);

    ////////////////////////////////////////////////////////////////////////////
    // register storage
    reg  [3:0] trigger_strobe_reg;
    reg  [7:0] line_config_a_reg;
    reg  [7:0] line_config_b_reg;
    reg  [7:0] cycle_period_a_reg;
    reg  [7:0] cycle_period_b_reg;
    reg        trig_pulse_reg;

    wire hit_trig  = reg_wr_i && (reg_addr_i == `TCL_OFS_TRIGGER_STROBE);
    wire local_wr  = reg_wr_i && chip_match_i;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            trigger_strobe_reg <= `TCL_TRIG_RESET;
            trig_pulse_reg     <= 1'b0;
            line_config_a_reg  <= `TCL_LC_RESET;
            line_config_b_reg  <= `TCL_LC_RESET;
            cycle_period_a_reg <= `TCL_CP_RESET;
            cycle_period_b_reg <= `TCL_CP_RESET;
        end else begin
            trig_pulse_reg <= hit_trig;
            if (hit_trig) trigger_strobe_reg <= reg_wdata_i[`TCL_TRIG_CODE_MSB:`TCL_TRIG_CODE_LSB];
            if (local_wr) begin
                case (reg_addr_i)
                    `TCL_OFS_LINE_CONFIG_A:  line_config_a_reg  <= reg_wdata_i;
                    `TCL_OFS_LINE_CONFIG_B:  line_config_b_reg  <= reg_wdata_i;
                    `TCL_OFS_CYCLE_PERIOD_A: cycle_period_a_reg <= reg_wdata_i;
                    `TCL_OFS_CYCLE_PERIOD_B: cycle_period_b_reg <= reg_wdata_i;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path; trigger reads back zero
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i && chip_match_i;
            if (reg_rd_i && chip_match_i) begin
                case (reg_addr_i)
                    `TCL_OFS_LINE_CONFIG_A:  reg_rdata_o <= line_config_a_reg;
                    `TCL_OFS_LINE_CONFIG_B:  reg_rdata_o <= line_config_b_reg;
                    `TCL_OFS_CYCLE_PERIOD_A: reg_rdata_o <= cycle_period_a_reg;
                    `TCL_OFS_CYCLE_PERIOD_B: reg_rdata_o <= cycle_period_b_reg;
                    default:                 reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trigger matching
    function code_hit;
        input       enable;
        input [3:0] assigned;
        input [3:0] written;
        begin
            code_hit = enable && ((written == assigned) || (written == `TCL_TRIG_GLOBAL_CODE));
        end
    endfunction

    wire start_a = trig_pulse_reg && code_hit(code_match_on_a_i, assigned_start_code_a_i, trigger_strobe_reg);
    wire start_b = trig_pulse_reg && code_hit(code_match_on_b_i, assigned_start_code_b_i, trigger_strobe_reg);

    ////////////////////////////////////////////////////////////////////////////
    // front-end fields
    assign threshold_type_sel_a_o  = line_config_a_reg[`TCL_LC_THRESH_BIT];
    assign current_dir_sel_a_o     = line_config_a_reg[`TCL_LC_DIR_BIT];
    assign current_level_sel_a_o   = line_config_a_reg[`TCL_LC_LEVEL_MSB:`TCL_LC_LEVEL_LSB];
    assign low_side_polarity_a_o   = line_config_a_reg[`TCL_LC_LOWSIDE_BIT] & ~line_config_a_reg[`TCL_LC_TOTEM_BIT];
    assign totem_pole_mode_a_o     = line_config_a_reg[`TCL_LC_TOTEM_BIT];
    assign line_driver_off_a_o     = line_config_a_reg[`TCL_LC_DRV_OFF_BIT];
    assign rx_glitch_filter_on_a_o = line_config_a_reg[`TCL_LC_FILTER_BIT];

    assign threshold_type_sel_b_o  = line_config_b_reg[`TCL_LC_THRESH_BIT];
    assign current_dir_sel_b_o     = line_config_b_reg[`TCL_LC_DIR_BIT];
    assign current_level_sel_b_o   = line_config_b_reg[`TCL_LC_LEVEL_MSB:`TCL_LC_LEVEL_LSB];
    assign low_side_polarity_b_o   = line_config_b_reg[`TCL_LC_LOWSIDE_BIT] & ~line_config_b_reg[`TCL_LC_TOTEM_BIT];
    assign totem_pole_mode_b_o     = line_config_b_reg[`TCL_LC_TOTEM_BIT];
    assign line_driver_off_b_o     = line_config_b_reg[`TCL_LC_DRV_OFF_BIT];
    assign rx_glitch_filter_on_b_o = line_config_b_reg[`TCL_LC_FILTER_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // channels
    tcl_channel #(
        .UNIT_CYC (UNIT_CYC),
        .FILT_CYC (FILT_CYC)
    ) u_chan_a (
        .ref_clk_i        (ref_clk_i),
        .rst_i            (rst_i),
        .line_cfg_i       (line_config_a_reg),
        .period_cfg_i     (cycle_period_a_reg),
        .cycle_timer_on_i (cycle_timer_on_a_i),
        .trig_start_i     (start_a),
        .tx_data_i        (tx_data_a_i),
        .line_pin_i       (line_pin_a_i),
        .line_pin_o       (line_pin_a_o),
        .line_pin_oe_o    (line_pin_a_oe_o),
        .rx_data_o        (rx_data_a_o),
        .tx_start_o       (tx_start_a_o),
        .timer_running_o  (timer_running_a_o)
    );

    tcl_channel #(
        .UNIT_CYC (UNIT_CYC),
        .FILT_CYC (FILT_CYC)
    ) u_chan_b (
        .ref_clk_i        (ref_clk_i),
        .rst_i            (rst_i),
        .line_cfg_i       (line_config_b_reg),
        .period_cfg_i     (cycle_period_b_reg),
        .cycle_timer_on_i (cycle_timer_on_b_i),
        .trig_start_i     (start_b),
        .tx_data_i        (tx_data_b_i),
        .line_pin_i       (line_pin_b_i),
        .line_pin_o       (line_pin_b_o),
        .line_pin_oe_o    (line_pin_b_oe_o),
        .rx_data_o        (rx_data_b_o),
        .tx_start_o       (tx_start_b_o),
        .timer_running_o  (timer_running_b_o)
    );

endmodule // tcl_bank

// ==== test/tcl_host_model.sv ====
// register host model issuing strobe-bus writes and reads to the bank
`timescale 1ns/1ps
module tcl_host_model (
    // clock
    input  wire       ref_clk_i,
    // request side
    output reg        reg_wr_o,
    output reg        reg_rd_o,
    output reg        chip_match_o,
    output reg  [4:0] reg_addr_o,
    output reg  [7:0] reg_wdata_o,
    // answer side
    input  wire [7:0] reg_rdata_i,
    input  wire       reg_rvalid_i
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        chip_match_o = 1'b0;
        reg_addr_o = 5'h00;
        reg_wdata_o = 8'h00;
    end
    ////////////////////////////////////////////////////////////////
    task wr(input [4:0] a, input [7:0] d, input sel);
        begin
            @(posedge ref_clk_i);
            // never programs the invalid time base
            reg_wr_o <= !((a == 5'h12 || a == 5'h13) && d[7:6] == 2'h3);
            chip_match_o <= sel;
            reg_addr_o <= a;
            reg_wdata_o <= d;
            @(posedge ref_clk_i);
            reg_wr_o <= 1'b0;
            chip_match_o <= ~sel;
            reg_addr_o <= ~a;
            reg_wdata_o <= ~d;
        end
    endtask
    task rd(input [4:0] a, output [7:0] d, output ok);
        integer i;
        begin
            ok = 1'b0;
            d = 8'h00;
            @(posedge ref_clk_i);
            reg_rd_o <= 1'b1;
            chip_match_o <= 1'b1;
            reg_addr_o <= a;
            @(posedge ref_clk_i);
            reg_rd_o <= 1'b0;
            chip_match_o <= 1'b0;
            reg_addr_o <= ~a;
            for (i = 0; i < 4 && !ok; i = i + 1) begin
                @(posedge ref_clk_i);
                if (reg_rvalid_i === 1'b1) begin
                    ok = 1'b1;
                    d = reg_rdata_i;
                end
            end
        end
    endtask
endmodule // tcl_host_model

// ==== test/tcl_bank_chk.sv ====
// concurrent checks on the ports of the trigger/line/cycle bank
`timescale 1ns/1ps
`include "tcl_defines.vh"
module tcl_bank_chk #(
    parameter UNIT_CYC = 4,
    parameter FILT_CYC = 3
) (
    // watched ports
    input wire       ref_clk_i,
    input wire       rst_i,
    input wire       reg_wr_i,
    input wire       chip_match_i,
    input wire [4:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire [3:0] assigned_start_code_a_i,
    input wire [3:0] assigned_start_code_b_i,
    input wire       code_match_on_a_i,
    input wire       code_match_on_b_i,
    input wire       cycle_timer_on_a_i,
    input wire       tx_data_a_i,
    input wire       tx_start_a_o,
    input wire       tx_start_b_o,
    input wire       timer_running_a_o,
    input wire       line_pin_a_o,
    input wire       line_pin_a_oe_o,
    input wire       threshold_type_sel_a_o,
    input wire       current_dir_sel_a_o,
    input wire [1:0] current_level_sel_a_o,
    input wire       low_side_polarity_a_o,
    input wire       totem_pole_mode_a_o,
    input wire       line_driver_off_a_o,
    input wire       rx_glitch_filter_on_a_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    wire trig_wr = reg_wr_i && reg_addr_i == `TCL_OFS_TRIGGER_STROBE;
    wire cfg_wr  = reg_wr_i && chip_match_i && reg_addr_i == `TCL_OFS_LINE_CONFIG_A;
    ////////////////////////////////////////////////////////////////
    AST_TRIG_A: assert property (trig_wr && code_match_on_a_i &&
        (reg_wdata_i[3:0] == assigned_start_code_a_i || reg_wdata_i[3:0] == 4'h0) |=> tx_start_a_o)
        else $error("channel a start missing after matching trigger");
    AST_TRIG_B_ANY_ADDR: assert property (trig_wr && !chip_match_i && code_match_on_b_i &&
        reg_wdata_i[3:0] == assigned_start_code_b_i |=> tx_start_b_o)
        else $error("unaddressed trigger not taken on channel b");
    AST_TRIG_IGNORED: assert property (trig_wr && !code_match_on_a_i && !timer_running_a_o |=> !tx_start_a_o)
        else $error("start on channel a with matching disabled");
    AST_START_ONE_CYCLE: assert property (trig_wr && !timer_running_a_o ##1 !trig_wr |=> !tx_start_a_o)
        else $error("start pulse longer than one cycle");
    AST_LC_FIELDS: assert property (cfg_wr |=>
        {threshold_type_sel_a_o, current_dir_sel_a_o, current_level_sel_a_o} == $past(reg_wdata_i[7:4]) &&
        {totem_pole_mode_a_o, line_driver_off_a_o, rx_glitch_filter_on_a_o} == $past(reg_wdata_i[2:0]))
        else $error("line config fields differ from written value");
    AST_LOWSIDE: assert property (cfg_wr && !reg_wdata_i[2] |=> low_side_polarity_a_o == $past(reg_wdata_i[3]))
        else $error("polarity field differs from written value");
    AST_LOWSIDE_IGN: assert property (totem_pole_mode_a_o |-> !low_side_polarity_a_o)
        else $error("polarity active in push-pull mode");
    AST_DRV_OFF: assert property ($past(line_driver_off_a_o) |-> !line_pin_a_oe_o)
        else $error("pin driven while driver disabled");
    AST_PUSHPULL: assert property ($past(totem_pole_mode_a_o && !line_driver_off_a_o) |->
        line_pin_a_oe_o && line_pin_a_o == $past(tx_data_a_i))
        else $error("push-pull pin does not follow transmit data");
    AST_TIMER_IDLE: assert property (!cycle_timer_on_a_i |=> !timer_running_a_o)
        else $error("cycle timer running while disabled");
endmodule // tcl_bank_chk
bind tcl_bank tcl_bank_chk #(.UNIT_CYC(UNIT_CYC), .FILT_CYC(FILT_CYC)) u_chk (.*);

// ==== test/tcl_bank_bench.sv ====
// self-checking bench of the trigger, line configuration and cycle timer bank
`timescale 1ns/1ps
module tcl_bank_bench;
    localparam UC = 4;
    localparam FC = 3;
    reg        ref_clk_i, rst_i, mat_a, mat_b, ton_a, ton_b, tx_a, tx_b, ext_a, ext_b;
    reg  [3:0] asg_a, asg_b;
    wire       wr, rd, sel, rvalid, st_a, st_b, run_a, run_b, rx_a, rx_b, po_a, oe_a, po_b, oe_b;
    wire [4:0] addr;
    wire [7:0] wdata, rdata, fb;
    wire       pin_a = oe_a ? po_a : ext_a;
    wire       pin_b = oe_b ? po_b : ext_b;
    integer    error_cnt, n_checks;
    tcl_host_model HOST (.ref_clk_i(ref_clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .chip_match_o(sel),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
    tcl_bank #(.UNIT_CYC(UC), .FILT_CYC(FC)) DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(wr),
        .reg_rd_i(rd), .chip_match_i(sel), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .assigned_start_code_a_i(asg_a), .assigned_start_code_b_i(asg_b),
        .code_match_on_a_i(mat_a), .code_match_on_b_i(mat_b), .cycle_timer_on_a_i(ton_a),
        .cycle_timer_on_b_i(ton_b), .tx_data_a_i(tx_a), .tx_data_b_i(tx_b), .tx_start_a_o(st_a),
        .tx_start_b_o(st_b), .timer_running_a_o(run_a), .timer_running_b_o(run_b), .rx_data_a_o(rx_a),
        .rx_data_b_o(rx_b), .line_pin_a_i(pin_a), .line_pin_a_o(po_a), .line_pin_a_oe_o(oe_a),
        .line_pin_b_i(pin_b), .line_pin_b_o(po_b), .line_pin_b_oe_o(oe_b), .threshold_type_sel_a_o(),
        .current_dir_sel_a_o(), .current_level_sel_a_o(), .low_side_polarity_a_o(), .totem_pole_mode_a_o(),
        .line_driver_off_a_o(), .rx_glitch_filter_on_a_o(), .threshold_type_sel_b_o(fb[7]),
        .current_dir_sel_b_o(fb[6]), .current_level_sel_b_o(fb[5:4]), .low_side_polarity_b_o(fb[3]),
        .totem_pole_mode_b_o(fb[2]), .line_driver_off_b_o(fb[1]), .rx_glitch_filter_on_b_o(fb[0]));
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    ////////////////////////////////////////////////////////////////
    task tick(input integer n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task report_and_stop;
        begin
            if (error_cnt == 0 && n_checks > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
            end
        end
    endtask
    task rd_chk(input [4:0] a, input [7:0] exp);
        reg [7:0] d;
        reg       ok;
        begin
            HOST.rd(a, d, ok);
            if (ok !== 1'b1) begin
                error_cnt = error_cnt + 1;
                report_and_stop;
            end else check(d, exp);
        end
    endtask
    task trig_chk(input [7:0] d, input [1:0] exp);
        begin
            HOST.wr(5'h0F, d, 1'b0);
            tick(1);
            check({st_a, st_b}, exp);
            tick(1);
            check({st_a, st_b}, 2'h0);
        end
    endtask
    task period_chk(input integer exp);
        integer n;
        begin
            n = 0;
            tick(1);
            while (st_a !== 1'b1 && n < 2000) begin
                n = n + 1;
                tick(1);
            end
            check(n + 1, exp);
            if (n >= 2000) report_and_stop;
        end
    endtask
    task timer_chk(input [7:0] p, input integer exp);
        begin
            HOST.wr(5'h12, p, 1'b1);
            @(posedge ref_clk_i) ton_a <= 1'b1;
            tick(20);
            check(run_a, 1'b0);
            HOST.wr(5'h0F, 8'h05, 1'b1);
            tick(1);
            check(st_a, 1'b1);
            period_chk(exp);
            period_chk(exp);
            @(posedge ref_clk_i) ton_a <= 1'b0;
            tick(3);
            check(run_a, 1'b0);
        end
    endtask
    task line_chk(input [7:0] cfg, input tx, input [1:0] exp);
        begin
            HOST.wr(5'h10, cfg, 1'b1);
            @(posedge ref_clk_i) tx_a <= tx;
            tick(2);
            check({oe_a, po_a & oe_a}, exp);
        end
    endtask
    task filter_chk;
        begin
            HOST.wr(5'h10, 8'h03, 1'b1);
            @(posedge ref_clk_i) ext_a <= 1'b1;
            tick(2);
            ext_a <= 1'b0;
            tick(FC + 4);
            check(rx_a, 1'b0);
            ext_a <= 1'b1;
            tick(FC);
            check(rx_a, 1'b0);
            tick(4);
            check(rx_a, 1'b1);
            HOST.wr(5'h10, 8'h02, 1'b1);
            @(posedge ref_clk_i) ext_a <= 1'b0;
            tick(2);
            check(rx_a, 1'b0);
        end
    endtask
    initial begin
        error_cnt = 0;
        n_checks = 0;
        {rst_i, mat_a, mat_b, ton_a, ton_b, tx_a, tx_b, ext_a, ext_b} = 9'h100;
        asg_a = 4'h5;
        asg_b = 4'h9;
        tick(10);
        rst_i <= 1'b0;
        rd_chk(5'h0F, 8'h00);
        rd_chk(5'h10, 8'h02);
        rd_chk(5'h11, 8'h02);
        rd_chk(5'h12, 8'h00);
        rd_chk(5'h13, 8'h00);
        rd_chk(5'h1F, 8'h00);
        HOST.wr(5'h10, 8'hF5, 1'b1);
        HOST.wr(5'h11, 8'h3A, 1'b1);
        HOST.wr(5'h12, 8'hBF, 1'b1);
        HOST.wr(5'h13, 8'h41, 1'b1);
        HOST.wr(5'h10, 8'h00, 1'b0);
        rd_chk(5'h10, 8'hF5);
        rd_chk(5'h11, 8'h3A);
        check(fb, 8'h3A);
        rd_chk(5'h12, 8'hBF);
        rd_chk(5'h13, 8'h41);
        HOST.wr(5'h11, 8'h04, 1'b1);
        @(posedge ref_clk_i) tx_b <= 1'b1;
        tick(3);
        check({oe_b, po_b, rx_b}, 3'h7);
        @(posedge ref_clk_i) {mat_a, mat_b} <= 2'h3;
        trig_chk(8'hF5, 2'h2);
        trig_chk(8'h09, 2'h1);
        trig_chk(8'h00, 2'h3);
        trig_chk(8'h07, 2'h0);
        check({run_a, run_b}, 2'h0);
        @(posedge ref_clk_i) mat_a <= 1'b0;
        trig_chk(8'h05, 2'h0);
        trig_chk(8'h00, 2'h1);
        @(posedge ref_clk_i) mat_a <= 1'b1;
        timer_chk(8'h02, 2 * UC);
        timer_chk(8'h41, (64 + 4) * UC);
        timer_chk(8'h80, 320 * UC);
        line_chk(8'h04, 1'b1, 2'h3);
        line_chk(8'h04, 1'b0, 2'h2);
        line_chk(8'h0C, 1'b0, 2'h2);
        line_chk(8'h08, 1'b1, 2'h0);
        line_chk(8'h08, 1'b0, 2'h2);
        line_chk(8'h00, 1'b1, 2'h3);
        line_chk(8'h00, 1'b0, 2'h0);
        line_chk(8'h06, 1'b1, 2'h0);
        filter_chk;
        report_and_stop;
    end
endmodule // tcl_bank_bench
